/* File: logic/rvt_defs.svh */
// Purpose: Constants for the reset entry and vector table map
// Assumes: Program addresses are 24 bits, two units per entry
// Notes: Included by the package and the top module
`ifndef RVT_DEFS_SVH
`define RVT_DEFS_SVH
`define RVT_ADDR_W 24
`define RVT_RESET_ADDR 24'h00_0000
`define RVT_PRI_BASE 24'h00_0004
`define RVT_ALT_OFFSET 24'h00_0100
`define RVT_TRAP_FIRST 4'h1
`define RVT_NUM_TRAPS 8
`define RVT_IRQ_FIRST 8'h08
`define RVT_NUM_IRQ 118
`define RVT_IRQ_W 7
`endif

/* File: logic/rvt_pkg.sv */
// Purpose: Types for the reset entry and vector table map
// Assumes: rvt_defs.svh holds the numbers
// Notes: Request and answer travel as packed structs
`include "rvt_defs.svh"
package rvt_pkg;
   typedef enum logic [2:0] {
      RVT_TRAP_OSC,
      RVT_TRAP_ADDR,
      RVT_TRAP_STACK,
      RVT_TRAP_MATH,
      RVT_TRAP_DMA
   } rvt_trap_t;
   typedef enum {RVT_RESET, RVT_RUN} rvt_phase_t;
   typedef struct packed {
      logic trap_valid;
      logic [2:0] trap_code;
      logic irq_valid;
      logic [`RVT_IRQ_W-1:0] irq_num;
      logic alt_table_select;
   } rvt_req_t;
   typedef struct packed {
      logic fetch_valid;
      logic [`RVT_ADDR_W-1:0] fetch_addr;
      logic is_trap;
      logic [`RVT_IRQ_W-1:0] entry_index;
   } rvt_ans_t;
   typedef struct packed {
      rvt_phase_t phase;
      logic start_fetch;
      logic [`RVT_ADDR_W-1:0] program_counter;
      logic load_pc;
      rvt_ans_t ans;
   } rvt_state_t;
endpackage

/* File: logic/rvt_map.sv */
// Purpose: Reset entry and vector table address generation
// Assumes: Requests come from same-clock interrupt logic
// Notes: Every output is a field of the registered state
`timescale 1ns/1ps
`include "rvt_defs.svh"
module rvt_map
   import rvt_pkg::*;
#(
   parameter int NUM_IRQ = `RVT_NUM_IRQ
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire rvt_req_t req,
   input wire logic vec_data_valid,
   input wire logic [`RVT_ADDR_W-1:0] vec_data,
   output rvt_ans_t ans,
   output logic start_fetch,
   output logic [`RVT_ADDR_W-1:0] program_counter,
   output logic load_pc
);
   // Table layout from the shared constants
   localparam logic [`RVT_ADDR_W-1:0] RESET_ADDR = `RVT_RESET_ADDR;
   localparam logic [`RVT_ADDR_W-1:0] PRI_BASE = `RVT_PRI_BASE;
   localparam logic [`RVT_ADDR_W-1:0] ALT_OFFSET = `RVT_ALT_OFFSET;
   // Slot numbers count entries from the table base
   localparam logic [7:0] TRAP_FIRST = {4'h0, `RVT_TRAP_FIRST};
   localparam logic [7:0] IRQ_FIRST = `RVT_IRQ_FIRST;
   localparam logic [2:0] LAST_TRAP = 3'(RVT_TRAP_DMA);
   localparam int TRAP_SLOTS = `RVT_NUM_TRAPS;

   // Parameter checks: the vector count must fit the table and its field
   if (NUM_IRQ < 1) begin : g_irq_low
      $error("NUM_IRQ must be at least one");
   end
   if (NUM_IRQ > `RVT_NUM_IRQ) begin : g_irq_high
      $error("NUM_IRQ exceeds the interrupt vectors of one table");
   end
   if (NUM_IRQ > (1 << `RVT_IRQ_W)) begin : g_irq_field
      $error("NUM_IRQ does not fit the interrupt number field");
   end
   // The index field carries a trap code or an interrupt number
   if (`RVT_IRQ_W != 7) begin : g_index_w
      $error("Index field must be seven bits wide");
   end

   // Layout checks: a handler address is one 24-bit entry
   if (`RVT_ADDR_W != 24) begin : g_addr_w
      $error("Vector entries must be 24 bits wide");
   end
   // The reset jump takes the two words below the table base
   if (RESET_ADDR + 24'h00_0004 != PRI_BASE) begin : g_reset_words
      $error("Table base must follow the two reset words");
   end
   // Entries are two units apart, so both table bases must be even
   if (PRI_BASE[0] != 1'b0) begin : g_pri_even
      $error("Primary table base must be even");
   end
   if (ALT_OFFSET[0] != 1'b0) begin : g_alt_even
      $error("Alternate table offset must be even");
   end
   // Reserved word, traps and their reserved words end where interrupts start
   if (int'(IRQ_FIRST) != TRAP_SLOTS) begin : g_trap_slots
      $error("Interrupt slots must follow the trap slots");
   end
   if (int'(TRAP_FIRST) + int'(LAST_TRAP) >= TRAP_SLOTS) begin : g_trap_fit
      $error("Trap vectors overrun the trap slots");
   end
   // The whole primary table must sit below the alternate one
   if (2 * (TRAP_SLOTS + NUM_IRQ) > int'(ALT_OFFSET)) begin : g_alt_gap
      $error("Primary table overlaps the alternate table");
   end

   // Registered state and its next value
   rvt_state_t st;
   rvt_state_t next_st;

   // Request decode results, settled within the cycle
   logic trap_hit;
   logic irq_hit;
   logic lookup_hit;
   logic lookup_is_trap;
   logic [`RVT_IRQ_W-1:0] lookup_index;
   logic [7:0] lookup_slot;
   logic [`RVT_ADDR_W-1:0] lookup_addr;

   // A trap request names one of the five implemented trap vectors
   function automatic logic trap_code_ok(input logic [2:0] code);
      return code <= LAST_TRAP;
   endfunction

   // An interrupt request names a vector that this table holds
   function automatic logic irq_num_ok(input logic [`RVT_IRQ_W-1:0] num);
      return 32'(num) < NUM_IRQ;
   endfunction

   // Slot of a trap vector: the reserved word at the base comes first
   function automatic logic [7:0] trap_slot(input logic [2:0] code);
      return {5'h00, code} + TRAP_FIRST;
   endfunction

   // Slot of an interrupt vector: after the traps and two reserved words
   function automatic logic [7:0] irq_slot(input logic [`RVT_IRQ_W-1:0] num);
      return {1'b0, num} + IRQ_FIRST;
   endfunction

   // Base of the table in use; the alternate one sits above the primary
   function automatic logic [`RVT_ADDR_W-1:0] table_base(input logic alt);
      logic [`RVT_ADDR_W-1:0] base;
      base = PRI_BASE;
      if (alt) begin
         base = PRI_BASE + ALT_OFFSET;
      end
      return base;
   endfunction

   // Entry address: table base plus two address units per slot
   function automatic logic [`RVT_ADDR_W-1:0] entry_addr(input logic alt,
                                                         input logic [7:0] slot);
      return table_base(alt) + {15'h0000, slot, 1'b0};
   endfunction

   // Answer word for one lookup; the valid bit lasts a single cycle
   function automatic rvt_ans_t make_answer(input logic is_trap,
                                            input logic [`RVT_IRQ_W-1:0] index,
                                            input logic [`RVT_ADDR_W-1:0] addr);
      rvt_ans_t a;
      a = '0;
      a.fetch_valid = 1'b1;
      a.is_trap = is_trap;
      a.entry_index = index;
      a.fetch_addr = addr;
      return a;
   endfunction

   // Reset entry: straight to address zero, no table lookup and no arbitration
   function automatic rvt_state_t reset_entry(input rvt_state_t s);
      rvt_state_t n;
      n = s;
      n.phase = RVT_RUN;
      n.start_fetch = 1'b1;
      n.program_counter = RESET_ADDR;
      return n;
   endfunction

   // Handler entry: the fetched vector word becomes the program counter
   function automatic rvt_state_t load_handler(input rvt_state_t s,
                                               input logic [`RVT_ADDR_W-1:0] addr);
      rvt_state_t n;
      n = s;
      n.program_counter = addr;
      n.load_pc = 1'b1;
      return n;
   endfunction

   // Request decode: traps sit lower in the table, so they outrank interrupts
   always_comb begin
      // Interrupt path by default
      trap_hit = req.trap_valid && trap_code_ok(req.trap_code);
      irq_hit = req.irq_valid && irq_num_ok(req.irq_num);
      lookup_hit = trap_hit || irq_hit;
      lookup_is_trap = trap_hit;
      lookup_index = req.irq_num;
      lookup_slot = irq_slot(req.irq_num);
      if (trap_hit) begin
         // A trap drops any coincident interrupt request
         lookup_index = {4'h0, req.trap_code};
         lookup_slot = trap_slot(req.trap_code);
      end
      lookup_addr = entry_addr(req.alt_table_select, lookup_slot);
   end

   // Next state: reset entry first, then table lookups and handler loads
   always_comb begin
      next_st = st;
      next_st.start_fetch = 1'b0;
      next_st.load_pc = 1'b0;
      next_st.ans.fetch_valid = 1'b0;
      case (st.phase)
         RVT_RESET: begin
            next_st = reset_entry(next_st);
         end
         RVT_RUN: begin
            // Answer a lookup; address, index and kind stand until the next one
            if (lookup_hit) begin
               next_st.ans = make_answer(lookup_is_trap, lookup_index, lookup_addr);
            end
            // Load the handler address that the fetch side read
            if (vec_data_valid) begin
               next_st = load_handler(next_st, vec_data);
            end
         end
         default: begin
            next_st.phase = RVT_RESET;
         end
      endcase
   end

   // State register; reset clears everything, program counter to zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Lookup answer straight from the state register
   assign ans = st.ans;
   // Reset entry pulse
   assign start_fetch = st.start_fetch;
   // Program counter and its load pulse
   assign program_counter = st.program_counter;
   assign load_pc = st.load_pc;
endmodule

/* File: tb/rvt_cpu_model.sv */
// Purpose: Fetch side model that reads handler words from the vector table
// Assumes: Handler for an entry sits 0x200 above the entry address
// Notes: Data line scrambles between fetches; reset word jumps to start-up code
`timescale 1ns/1ps
`include "rvt_defs.svh"
module rvt_cpu_model
   import rvt_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire rvt_ans_t ans,
   input wire logic start_fetch,
   output logic vec_data_valid,
   output logic [`RVT_ADDR_W-1:0] vec_data
);
   // Start-up code begins right above the alternate table
   localparam logic [`RVT_ADDR_W-1:0] START_ADDR = 24'h00_0200;
   // Reset word jumps to start-up code; each vector entry names its handler
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vec_data_valid <= 1'b0;
         vec_data <= 24'h00_0000;
      end else begin
         vec_data_valid <= ans.fetch_valid || start_fetch;
         if (start_fetch) begin
            vec_data <= START_ADDR;
         end else if (ans.fetch_valid) begin
            vec_data <= ans.fetch_addr + START_ADDR;
         end else begin
            vec_data <= ~vec_data;
         end
      end
   end
endmodule

/* File: tb/rvt_map_chk.sv */
// Purpose: Port assertions for the vector map
// Assumes: One clock, async active-low reset
// Notes: Bound to rvt_map below
`timescale 1ns/1ps
`include "rvt_defs.svh"
module rvt_map_chk
   import rvt_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire rvt_req_t req,
   input wire logic vec_data_valid,
   input wire logic [`RVT_ADDR_W-1:0] vec_data,
   input wire rvt_ans_t ans,
   input wire logic start_fetch,
   input wire logic [`RVT_ADDR_W-1:0] program_counter,
   input wire logic load_pc
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Requests taken only after the first edge out of reset
   sequence s_irq;
      req.irq_valid && !req.trap_valid && req.irq_num < 7'h76 && !$rose(rst_n);
   endsequence
   sequence s_trap;
      req.trap_valid && req.trap_code < 3'h5 && !$rose(rst_n);
   endsequence
   a_irq_addr: assert property (s_irq |=> ans.fetch_valid && ans.fetch_addr == 24'h00_0014
      + {$past(req.irq_num), 1'b0} + {$past(req.alt_table_select), 8'h00}) else $error("irq addr");
   a_irq_index: assert property (s_irq |=> !ans.is_trap
      && ans.entry_index == $past(req.irq_num)) else $error("irq index");
   a_trap_addr: assert property (s_trap |=>
      ans.fetch_valid && ans.is_trap && ans.fetch_addr ==
      24'h00_0006 + {$past(req.trap_code), 1'b0} + {$past(req.alt_table_select), 8'h00})
      else $error("trap addr");
   a_trap_index: assert property (s_trap |=>
      ans.entry_index == {4'h0, $past(req.trap_code)}) else $error("trap index");
   a_no_answer: assert property (!(req.irq_valid && req.irq_num < 7'h76) &&
      !(req.trap_valid && req.trap_code < 3'h5) |=> !ans.fetch_valid)
      else $error("spurious answer");
   a_boot_pc: assert property ($rose(rst_n) |=> start_fetch && !ans.fetch_valid
      && program_counter == 24'h00_0000) else $error("boot fetch");
   a_pc_load: assert property (vec_data_valid && !$rose(rst_n) |=> load_pc
      && program_counter == $past(vec_data)) else $error("pc load");
   a_pc_hold: assert property (!vec_data_valid && !$rose(rst_n) |=> !load_pc
      && $stable(program_counter)) else $error("pc hold");
   a_addr_hold: assert property (!ans.fetch_valid |-> $stable(ans.fetch_addr))
      else $error("addr hold");
endmodule
bind rvt_map rvt_map_chk rvt_map_chk_inst (.clock(clock), .rst_n(rst_n), .req(req),
   .vec_data_valid(vec_data_valid), .vec_data(vec_data), .ans(ans), .start_fetch(start_fetch),
   .program_counter(program_counter), .load_pc(load_pc));

/* File: tb/test_rvt_map.sv */
// Purpose: Bench for the vector map
// Assumes: Inputs change on the falling edge
// Notes: Handler loads come from the fetch model
`timescale 1ns/1ps
`include "rvt_defs.svh"
module test_rvt_map;
   import rvt_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   rvt_req_t req = '0;
   rvt_ans_t ans;
   logic vec_data_valid;
   logic start_fetch;
   logic load_pc;
   logic [`RVT_ADDR_W-1:0] vec_data;
   logic [`RVT_ADDR_W-1:0] program_counter;
   int bad_count = 0;
   int n_compared = 0;
   rvt_map rvt_map_inst (.clock(clock), .rst_n(rst_n), .req(req), .vec_data_valid(vec_data_valid),
      .vec_data(vec_data), .ans(ans), .start_fetch(start_fetch),
      .program_counter(program_counter), .load_pc(load_pc));
   rvt_cpu_model rvt_cpu_model_inst (.clock(clock), .rst_n(rst_n), .ans(ans),
      .start_fetch(start_fetch), .vec_data_valid(vec_data_valid), .vec_data(vec_data));
   // Clock and watchdog
   initial forever #2 clock = ~clock;
   initial begin
      #20000;
      bad_count++;
      close_out();
   end
   task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (6) @(negedge clock);
      chk("pc_in_reset", program_counter, 24'h00_0000);
      rst_n = 1'b1;
      @(negedge clock);
      chk("start_fetch", start_fetch, 24'h00_0001);
      chk("boot_lookup", ans.fetch_valid, 24'h00_0000);
      repeat (2) @(negedge clock);
      chk("reset_jump", program_counter, 24'h00_0200);
      chk("reset_load", load_pc, 24'h00_0001);
   endtask
   task automatic ask(rvt_req_t r, logic v, logic [23:0] exp);
      req = r;
      @(negedge clock);
      chk("fetch_valid", ans.fetch_valid, {23'h00_0000, v});
      if (v) chk("fetch_addr", ans.fetch_addr, exp);
   endtask
   // Every interrupt vector of both tables back to back
   task automatic irq_sweep();
      for (int a = 0; a < 2; a++)
         for (int n = 0; n < 118; n++)
            ask('{1'b0, 3'h0, 1'b1, n[6:0], a[0]}, 1'b1, 24'h00_0014 + 2 * n + 256 * a);
      ask('{1'b0, 3'h0, 1'b1, 7'h76, 1'b0}, 1'b0, 24'h00_0000);
      ask('{1'b0, 3'h0, 1'b1, 7'h7F, 1'b1}, 1'b0, 24'h00_0000);
   endtask
   // Traps beat a coincident interrupt, unknown codes refused
   task automatic trap_order();
      for (int c = 0; c < 8; c++) begin
         ask('{1'b1, c[2:0], c < 5, 7'h00, c[0]}, c < 5,
            24'h00_0006 + 2 * c + 256 * c[0]);
         if (c < 5) begin
            chk("is_trap", ans.is_trap, 24'h00_0001);
            chk("trap_index", ans.entry_index, c[23:0]);
         end
      end
   endtask
   task automatic handler_load();
      ask('{1'b0, 3'h0, 1'b1, 7'h75, 1'b1}, 1'b1, 24'h00_01FE);
      req = '0;
      repeat (2) @(negedge clock);
      chk("load_pc", load_pc, 24'h00_0001);
      chk("program_counter", program_counter, 24'h00_03FE);
   endtask
   initial begin
      do_reset();
      irq_sweep();
      trap_order();
      handler_load();
      do_reset();
      close_out();
   end
endmodule
